// ===== design/dbk_defs.vh
`ifndef DBK_DEFS_VH
`define DBK_DEFS_VH

// Serial command codes
`define DBK_CMD_BACKGROUND   8'h90
`define DBK_CMD_READ_STATUS  8'hE4
`define DBK_CMD_WRITE_CTRL   8'hC4
`define DBK_CMD_READ_MATCH   8'hE2
`define DBK_CMD_WRITE_MATCH  8'hC2

// Status/control bit positions
`define DBK_BIT_PERMIT       7
`define DBK_BIT_ACTIVE       6
`define DBK_BIT_BKPT_EN      5
`define DBK_BIT_FTS          4
`define DBK_BIT_CLKSEL       3
`define DBK_BIT_WS           2
`define DBK_BIT_WSF          1
`define DBK_BIT_DVF          0

// Reset values
`define DBK_RST_SCR_NORMAL   8'h00
`define DBK_RST_SCR_DEBUG    8'hC8
`define DBK_RST_MATCH        16'h0000

`endif

// ===== design/dbk_breakpoint.v
// Contract
// - Compare every CPU bus address with one 16-bit match value.
// - Forced mode: match access halts CPU at next instruction boundary.
// - Tagged mode: tag matching opcode; halt only if it reaches queue end.
// - Tags apply to opcode fetches only; forced matches any access.
// - Enable bit 0 (reset) suppresses all breakpoint requests.
// - Force/tag select 1 means forced, 0 means tagged.
// - Both registers reached only by serial debug commands, not CPU map.
// - Permit bit cannot be written while CPU is halted.
// - Four status bits are read-only; control write never alters them.
// - Clock select bit always read/write, normal reset 0, debug reset 1; 0 alternate, 1 bus clock.
// - Permit bit once 1 stays 1 until normal reset.
// - Permit 0 refuses halt entry; non-intrusive commands still run.
// - Active flag is 1 while halted, 0 while user program runs.
// - Wait/stop flag 1 in WAIT/STOP or after forced exit into halt.
// - Background command forces CPU out of WAIT or STOP into halt.
// - Set failure flag when memory command collides with WAIT/STOP.
// - Data-valid failure flag unused, always zero.
// - Status read E4 returns byte; control write C4 carries byte.
// - Match read E2 returns 16 bits; match write C2 carries 16 bits.
// - Background command 90 halts only when permit bit is set.
`timescale 1ns/1ps
`include "dbk_defs.vh"

module dbk_breakpoint (
    input  wire        CLOCK,
    input  wire        RST_N,
    input  wire        RESET_INTO_DEBUG,
    input  wire        CMD_VALID,
    input  wire [7:0]  CMD_CODE,
    input  wire [15:0] CMD_WDATA,
    output reg  [15:0] CMD_RDATA,
    output reg         CMD_RVALID,
    input  wire        MEM_CMD_FAIL_WS,
    input  wire [15:0] CPU_ADDR,
    input  wire        CPU_ACCESS,
    input  wire        CPU_OPCODE_FETCH,
    input  wire        CPU_QUEUE_FLUSH,
    input  wire        CPU_QUEUE_END,
    input  wire        CPU_INSTR_BOUNDARY,
    input  wire        CPU_WAIT_STOP,
    input  wire        CPU_RESUME,
    output wire        HALT_REQUEST,
    output wire        HALTED,
    output wire        COMM_CLOCK_SELECT
);

    reg        permit_ff;
    reg        active_ff;
    reg        bkpt_en_ff;
    reg        fts_ff;
    reg        clksel_ff;
    reg        ws_ff;
    reg        wsf_ff;
    reg        force_pend_ff;
    reg  [2:0] tag_ff;
    reg  [15:0] match_ff;
    reg        strap_done_ff;

    localparam [7:0] SCR_DEBUG_RST = `DBK_RST_SCR_DEBUG;

    wire       addr_hit   = (CPU_ADDR == match_ff);
    wire       bkpt_live  = bkpt_en_ff & permit_ff & ~active_ff;
    wire       force_hit  = bkpt_live & fts_ff & CPU_ACCESS & addr_hit;
    wire       tag_hit    = bkpt_live & ~fts_ff & CPU_OPCODE_FETCH & addr_hit;

    wire       wr_ctrl    = CMD_VALID & (CMD_CODE == `DBK_CMD_WRITE_CTRL);
    wire       wr_match   = CMD_VALID & (CMD_CODE == `DBK_CMD_WRITE_MATCH);
    wire       rd_status  = CMD_VALID & (CMD_CODE == `DBK_CMD_READ_STATUS);
    wire       rd_match   = CMD_VALID & (CMD_CODE == `DBK_CMD_READ_MATCH);
    wire       bg_cmd     = CMD_VALID & (CMD_CODE == `DBK_CMD_BACKGROUND) & permit_ff;

    // Queue tracks tagged opcode positions; bit 0 is the queue end
    wire       tag_at_end = tag_ff[0] & CPU_QUEUE_END;
    wire       force_fire = (force_pend_ff | force_hit) & CPU_INSTR_BOUNDARY;
    wire       enter_halt = ~active_ff & (bg_cmd | ((force_fire | tag_at_end) & permit_ff));

    wire [7:0] status_byte;
    assign status_byte[`DBK_BIT_PERMIT]  = permit_ff;
    assign status_byte[`DBK_BIT_ACTIVE]  = active_ff;
    assign status_byte[`DBK_BIT_BKPT_EN] = bkpt_en_ff;
    assign status_byte[`DBK_BIT_FTS]     = fts_ff;
    assign status_byte[`DBK_BIT_CLKSEL]  = clksel_ff;
    assign status_byte[`DBK_BIT_WS]      = ws_ff | CPU_WAIT_STOP;
    assign status_byte[`DBK_BIT_WSF]     = wsf_ff;
    assign status_byte[`DBK_BIT_DVF]     = 1'b0;

    assign HALT_REQUEST      = enter_halt;
    assign HALTED            = active_ff;
    assign COMM_CLOCK_SELECT = clksel_ff;

    // Control and status register
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            permit_ff     <= 1'b0;
            active_ff     <= 1'b0;
            bkpt_en_ff    <= 1'b0;
            fts_ff        <= 1'b0;
            clksel_ff     <= 1'b0;
            ws_ff         <= 1'b0;
            wsf_ff        <= 1'b0;
            strap_done_ff <= 1'b0;
        end else if (!strap_done_ff) begin
            // Debug-mode reset values caught after release
            strap_done_ff <= 1'b1;
            if (RESET_INTO_DEBUG) begin
                permit_ff <= SCR_DEBUG_RST[`DBK_BIT_PERMIT];
                active_ff <= SCR_DEBUG_RST[`DBK_BIT_ACTIVE];
                clksel_ff <= SCR_DEBUG_RST[`DBK_BIT_CLKSEL];
            end
        end else begin
            if (wr_ctrl) begin
                if (!active_ff && CMD_WDATA[`DBK_BIT_PERMIT])
                    permit_ff <= 1'b1;
                bkpt_en_ff <= CMD_WDATA[`DBK_BIT_BKPT_EN];
                fts_ff     <= CMD_WDATA[`DBK_BIT_FTS];
                clksel_ff  <= CMD_WDATA[`DBK_BIT_CLKSEL];
            end
            // Status bits change only by hardware events and the background command
            if (enter_halt)
                active_ff <= 1'b1;
            else if (CPU_RESUME)
                active_ff <= 1'b0;
            if (bg_cmd && CPU_WAIT_STOP && !active_ff)
                ws_ff <= 1'b1;
            else if (CPU_RESUME)
                ws_ff <= 1'b0;
            if (MEM_CMD_FAIL_WS)
                wsf_ff <= 1'b1;
            else if (CPU_RESUME)
                wsf_ff <= 1'b0;
        end
    end

    // Match register and breakpoint tracking
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            match_ff      <= `DBK_RST_MATCH;
            force_pend_ff <= 1'b0;
            tag_ff        <= 3'h0;
        end else begin
            if (wr_match)
                match_ff <= CMD_WDATA;
            if (force_fire || enter_halt || !bkpt_live)
                force_pend_ff <= 1'b0;
            else if (force_hit)
                force_pend_ff <= 1'b1;
            if (CPU_QUEUE_FLUSH || enter_halt || !bkpt_en_ff)
                tag_ff <= 3'h0;
            else if (CPU_QUEUE_END)
                tag_ff <= {tag_hit, tag_ff[2:1]};
            else if (tag_hit)
                tag_ff <= tag_ff | 3'h4;
        end
    end

    // Command read data
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            CMD_RDATA  <= 16'h0000;
            CMD_RVALID <= 1'b0;
        end else begin
            CMD_RVALID <= rd_status | rd_match;
            if (rd_status)
                CMD_RDATA <= {8'h00, status_byte};
            else if (rd_match)
                CMD_RDATA <= match_ff;
        end
    end

endmodule // dbk_breakpoint

// ===== verif/dbk_host_model.sv
`timescale 1ns/1ps
module dbk_host_model (
    input  logic        CLOCK,
    input  logic        CMD_RVALID,
    input  logic [15:0] CMD_RDATA,
    output logic        CMD_VALID = 1'b0,
    output logic [7:0]  CMD_CODE = 8'h00,
    output logic [15:0] CMD_WDATA = 16'h0000
);
    task cmd(input logic [7:0] c, input logic [15:0] w);
        @(posedge CLOCK);
        CMD_VALID <= 1'b1;
        CMD_CODE <= c;
        CMD_WDATA <= w;
        @(posedge CLOCK);
        CMD_VALID <= 1'b0;
        CMD_WDATA <= ~w;
    endtask
    task rd(input logic [7:0] c, output logic [15:0] d);
        cmd(c, 16'h0000);
        #1 d = CMD_RVALID ? CMD_RDATA : ~CMD_RDATA;
    endtask
endmodule // dbk_host_model

// ===== verif/dbk_breakpoint_checker.sv
`timescale 1ns/1ps
`include "dbk_defs.vh"
module dbk_breakpoint_checker (
    input logic        CLOCK,
    input logic        RST_N,
    input logic        CMD_VALID,
    input logic [7:0]  CMD_CODE,
    input logic [15:0] CMD_WDATA,
    input logic [15:0] CMD_RDATA,
    input logic        CMD_RVALID,
    input logic        CPU_INSTR_BOUNDARY,
    input logic        CPU_QUEUE_END,
    input logic        CPU_RESUME,
    input logic        HALT_REQUEST,
    input logic        HALTED,
    input logic        COMM_CLOCK_SELECT
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    wire rd_st = CMD_VALID && CMD_CODE == `DBK_CMD_READ_STATUS;
    wire wr_c = CMD_VALID && CMD_CODE == `DBK_CMD_WRITE_CTRL;
    a_read_answer: assert property (
        rd_st || CMD_VALID && CMD_CODE == `DBK_CMD_READ_MATCH |=> CMD_RVALID)
        else $error("read not answered");
    a_status_fixed: assert property (rd_st |=> CMD_RDATA[15:8] == 8'h00 && !CMD_RDATA[0])
        else $error("status upper or dvf set");
    a_rdata_hold: assert property ($past(RST_N) && !CMD_RVALID |-> $stable(CMD_RDATA))
        else $error("read data moved");
    a_clock_select: assert property (wr_c |=> COMM_CLOCK_SELECT == $past(CMD_WDATA[3]))
        else $error("clock select not written");
    a_halt_enters: assert property (HALT_REQUEST |=> HALTED)
        else $error("halt not entered");
    a_resume_leaves: assert property (CPU_RESUME && !HALT_REQUEST && !CMD_VALID |=> !HALTED)
        else $error("halt not left");
    a_halt_cause: assert property (
        HALT_REQUEST |-> CPU_INSTR_BOUNDARY || CPU_QUEUE_END || CMD_VALID)
        else $error("halt without cause");
    a_active_steady: assert property (
        $past(RST_N) && !HALTED && !HALT_REQUEST && !CMD_VALID |=> !HALTED)
        else $error("halt from nowhere");
endmodule // dbk_breakpoint_checker
bind dbk_breakpoint dbk_breakpoint_checker dbk_breakpoint_checker_i (.*);

// ===== verif/dbk_breakpoint_tb_top.sv
`timescale 1ns/1ps
`include "dbk_defs.vh"
module dbk_breakpoint_tb_top;
    logic CLOCK = 0, RST_N = 0, RESET_INTO_DEBUG = 1, MEM_CMD_FAIL_WS = 0, CPU_WAIT_STOP = 0, CPU_RESUME = 0;
    logic CPU_ACCESS = 0, CPU_OPCODE_FETCH = 0, CPU_QUEUE_FLUSH = 0, CPU_QUEUE_END = 0, CPU_INSTR_BOUNDARY = 0;
    logic [15:0] CPU_ADDR = 16'h0000;
    wire CMD_VALID, CMD_RVALID, HALT_REQUEST, HALTED, COMM_CLOCK_SELECT;
    wire [7:0] CMD_CODE;
    wire [15:0] CMD_WDATA, CMD_RDATA;
    int err_count = 0, total_checks = 0;
    dbk_breakpoint dbk_breakpoint_i (.*);
    dbk_host_model dbk_host_model_i (.*);
    always #20 CLOCK = ~CLOCK;
    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task results;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task st(input logic [7:0] e);
        logic [15:0] d;
        dbk_host_model_i.rd(`DBK_CMD_READ_STATUS, d);
        chk("status", d, {8'h00, e});
    endtask
    // One CPU cycle: {access, fetch, flush, queue end, boundary}
    task cpu(input logic [15:0] a, input logic [4:0] v, input logic e);
        @(posedge CLOCK);
        CPU_ADDR <= a;
        {CPU_ACCESS, CPU_OPCODE_FETCH, CPU_QUEUE_FLUSH, CPU_QUEUE_END, CPU_INSTR_BOUNDARY} <= v;
        #1 chk("halt_req", {15'h0000, HALT_REQUEST}, {15'h0000, e});
        @(posedge CLOCK);
        {CPU_ACCESS, CPU_OPCODE_FETCH, CPU_QUEUE_FLUSH, CPU_QUEUE_END, CPU_INSTR_BOUNDARY} <= 5'h00;
    endtask
    task go;
        @(posedge CLOCK);
        CPU_RESUME <= 1'b1;
        @(posedge CLOCK);
        CPU_RESUME <= 1'b0;
        #1 chk("halted", {15'h0000, HALTED}, 16'h0000);
    endtask
    task t_reset(input logic d);
        @(posedge CLOCK);
        RST_N <= 1'b0;
        RESET_INTO_DEBUG <= d;
        repeat (8) @(posedge CLOCK);
        RST_N <= 1'b1;
        repeat (2) @(posedge CLOCK);
    endtask
    task t_normal;
        logic [15:0] d;
        t_reset(1'b1);
        st(8'hC8);
        go;
        t_reset(1'b0);
        st(8'h00);
        dbk_host_model_i.cmd(`DBK_CMD_BACKGROUND, 16'h0000);
        st(8'h00);
        dbk_host_model_i.cmd(`DBK_CMD_WRITE_CTRL, 16'h00FF);
        st(8'hB8);
        dbk_host_model_i.cmd(`DBK_CMD_WRITE_CTRL, 16'h0000);
        st(8'h80);
        cpu(16'h0000, 5'h11, 1'b0);
    endtask
    task t_forced;
        logic [15:0] d;
        dbk_host_model_i.cmd(`DBK_CMD_WRITE_MATCH, 16'h1234);
        dbk_host_model_i.rd(`DBK_CMD_READ_MATCH, d);
        chk("match", d, 16'h1234);
        dbk_host_model_i.cmd(`DBK_CMD_WRITE_CTRL, 16'h00B0);
        cpu(16'h1235, 5'h11, 1'b0);
        cpu(16'h1234, 5'h10, 1'b0);
        cpu(16'h0000, 5'h01, 1'b1);
        st(8'hF0);
        go;
    endtask
    task t_tagged;
        dbk_host_model_i.cmd(`DBK_CMD_WRITE_CTRL, 16'h00A0);
        cpu(16'h1234, 5'h11, 1'b0);
        cpu(16'h1234, 5'h18, 1'b0);
        cpu(16'h0000, 5'h04, 1'b0);
        repeat (3) cpu(16'h0000, 5'h02, 1'b0);
        cpu(16'h1234, 5'h18, 1'b0);
        repeat (2) cpu(16'h0000, 5'h02, 1'b0);
        cpu(16'h0000, 5'h02, 1'b1);
        go;
    endtask
    task t_wait;
        @(posedge CLOCK);
        CPU_WAIT_STOP <= 1'b1;
        @(posedge CLOCK);
        MEM_CMD_FAIL_WS <= 1'b1;
        @(posedge CLOCK);
        MEM_CMD_FAIL_WS <= 1'b0;
        st(8'hA6);
        dbk_host_model_i.cmd(`DBK_CMD_BACKGROUND, 16'h0000);
        CPU_WAIT_STOP <= 1'b0;
        st(8'hE6);
        go;
        st(8'hA0);
    endtask
    initial begin
        t_normal;
        t_forced;
        t_tagged;
        t_wait;
        results;
    end
    initial begin
        repeat (5000) @(posedge CLOCK);
        err_count++;
        results;
    end
endmodule // dbk_breakpoint_tb_top
